// ---- src/gpio_sense_detect_security.sv ----
// Functional notes
// - Each pin senses high, low, or off
// - Matching level raises that pin's detect
// - Default: port detect merges per-pin detects
// - Sense logic runs in run and off states
// - Secure and ordinary selectors, one per domain
// - Enabling sense on matching level detects immediately
// - Rising detect sets flag bit of pin index
// - Clear ignored while pin detect is high
// - Flags clear only by writing one
// - Sticky hit high while any flag of its own domain set
// - Clear leaving flags set gives new edge
// - Flags always readable, whatever source selected
// - Selector picks merged detect or sticky hit
// - Port detect also requests wake-up
// - Non-secure access to secure pins ignored
// - Filtered accesses still answer without error
// - Port-wide registers mask secure bits non-securely
// - Secure pin configuration hidden from non-secure
// - Secure selector reads zero, ignores non-secure
// - Non-secure and secure hits to event units
// - Input register lags pad two cycles
// - Disconnected input feeds neither input nor sense
//
// Purpose: Pin sense, sticky flags and split-security register port
// Assumes: AXI4-Lite slave on aclk; awprot/arprot bit 1 high marks non-secure
// Notes:   Ownership map comes from the protection unit on aclk
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module gpio_sense_detect_security #(
    parameter int NUM_PINS = 32
) (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [11:0]             awaddr,
    input  wire logic [2:0]              awprot,
    // AXI4-Lite write data
    input  wire logic                    wvalid,
    output logic                         wready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    // AXI4-Lite write response
    output logic                         bvalid,
    input  wire logic                    bready,
    output gpio_sense_pkg::axi_resp_t    bresp,
    // AXI4-Lite read address
    input  wire logic                    arvalid,
    output logic                         arready,
    input  wire logic [11:0]             araddr,
    input  wire logic [2:0]              arprot,
    // AXI4-Lite read data
    output logic                         rvalid,
    input  wire logic                    rready,
    output logic [31:0]                  rdata,
    output gpio_sense_pkg::axi_resp_t    rresp,
    // Pads
    input  wire logic [NUM_PINS-1:0]     pad_in,
    output logic [NUM_PINS-1:0]          pad_out,
    output logic [NUM_PINS-1:0]          pad_oe,
    // Protection unit
    input  wire logic [NUM_PINS-1:0]     pin_ownership_map,
    // Detect outputs
    output logic                         nonsecure_port_hit,
    output logic                         secure_port_hit,
    output logic                         nonsecure_port_event,
    output logic                         secure_port_event,
    output logic                         wake_request
);
    import gpio_sense_pkg::*;

    `include "gpio_sense_params.svh"

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
        reg_hit = (addr[11:2] == ofs[11:2]);
    endfunction : reg_hit
    function automatic logic cnf_hit(input logic [11:0] addr);
        logic [11:0] last;
        last = `OFS_PIN_CONFIGURATION_BASE + 12'(4 * (NUM_PINS - 1));
        cnf_hit = (addr[11:2] >= `OFS_PIN_CONFIGURATION_BASE >> 2)
                && (addr[11:2] <= last[11:2]);
    endfunction : cnf_hit
    function automatic logic [4:0] cnf_index(input logic [11:0] addr);
        cnf_index = addr[6:2];
    endfunction : cnf_index

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [NUM_PINS-1:0] out_r;
    logic [NUM_PINS-1:0] dir_r;
    logic [NUM_PINS-1:0] disconnect_r;
    sense_mode_t         sense_r [NUM_PINS];
    logic                mode_ns_r;
    logic                mode_sec_r;
    logic                drop_r;
    logic                ns_hit_r;
    logic                sec_hit_r;
    logic                ns_event_r;
    logic                sec_event_r;
    logic                aw_held_r;
    logic [11:0]         waddr_r;
    logic                wsec_r;
    logic                w_held_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    logic                bvalid_r;
    logic                rvalid_r;
    logic [31:0]         rdata_r;
    // Per-pin results
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] detect;
    logic [NUM_PINS-1:0] flags;
    logic [NUM_PINS-1:0] flag_clear;

    // ------------------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------------------
    // No gating by power state: cells run whenever aclk runs
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            pin_sense_cell u_cell (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .pad_in     (pad_in[gi]),
                .connected  (~disconnect_r[gi]),
                .sense_mode (sense_r[gi]),
                .flag_clear (flag_clear[gi]),
                .level      (level[gi]),
                .detect     (detect[gi]),
                .flag       (flags[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------------------
    logic wr_en;
    assign awready = !aw_held_r && !bvalid_r;
    assign wready  = !w_held_r && !bvalid_r;
    assign wr_en   = aw_held_r && w_held_r && !bvalid_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            waddr_r   <= 12'h000;
            wsec_r    <= 1'b0;
        end else if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            waddr_r   <= awaddr;
            wsec_r    <= !awprot[1];
        end else if (wr_en) begin
            aw_held_r <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r  <= 32'h00000000;
            wstrb_r  <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
        end else if (wr_en) begin
            w_held_r <= 1'b0;
        end
    end
    // Filtered writes still complete with OKAY so no fault is raised
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
        end else if (wr_en) begin
            bvalid_r <= 1'b1;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign bvalid = bvalid_r;
    assign bresp  = RESP_OKAY;
    logic [31:0]         strb_mask;
    logic [NUM_PINS-1:0] wmask;
    logic [NUM_PINS-1:0] wbits;
    logic                cnf_wr;
    logic [4:0]          cnf_idx;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            strb_mask[b*8 +: 8] = {8{wstrb_r[b]}};
        end
    end
    // Secure pins drop out of non-secure writes bit by bit
    assign wmask   = strb_mask[NUM_PINS-1:0] & (wsec_r ? {NUM_PINS{1'b1}} : ~pin_ownership_map);
    assign wbits   = wdata_r[NUM_PINS-1:0] & wmask;
    assign cnf_idx = cnf_index(waddr_r);
    assign cnf_wr  = wr_en && cnf_hit(waddr_r)
                  && (wsec_r || !pin_ownership_map[cnf_idx]);

    // ------------------------------------------------------------------------
    // Output and direction
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_r <= `RST_PORT_OUTPUT;
        end else if (wr_en && reg_hit(waddr_r, `OFS_PORT_OUTPUT_VALUE)) begin
            out_r <= (out_r & ~wmask) | wbits;
        end else if (wr_en && reg_hit(waddr_r, `OFS_PORT_OUTPUT_SET)) begin
            out_r <= out_r | wbits;
        end else if (wr_en && reg_hit(waddr_r, `OFS_PORT_OUTPUT_CLEAR)) begin
            out_r <= out_r & ~wbits;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_r <= `RST_PORT_DIRECTION;
        end else if (wr_en && reg_hit(waddr_r, `OFS_PORT_DIRECTION)) begin
            dir_r <= (dir_r & ~wmask) | wbits;
        end else if (wr_en && reg_hit(waddr_r, `OFS_PORT_DIRECTION_SET)) begin
            dir_r <= dir_r | wbits;
        end else if (wr_en && reg_hit(waddr_r, `OFS_PORT_DIRECTION_CLEAR)) begin
            dir_r <= dir_r & ~wbits;
        end else if (cnf_wr && wstrb_r[0]) begin
            dir_r[cnf_idx] <= wdata_r[`CNF_DIR_BIT];
        end
    end
    assign pad_out = out_r;
    assign pad_oe  = dir_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disconnect_r <= {NUM_PINS{`RST_INPUT_DISCONNECT}};
            for (int p = 0; p < NUM_PINS; p++) begin
                sense_r[p] <= SENSE_OFF;
            end
        end else if (cnf_wr) begin
            if (wstrb_r[0]) begin
                disconnect_r[cnf_idx] <= wdata_r[`CNF_DISCONNECT_BIT];
            end
            if (wstrb_r[2]) begin
                sense_r[cnf_idx] <= sense_mode_t'(wdata_r[`CNF_SENSE_MSB:`CNF_SENSE_LSB]);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sticky flags and source selectors
    // ------------------------------------------------------------------------
    logic flag_wr;
    assign flag_wr    = wr_en && reg_hit(waddr_r, `OFS_STICKY_SENSE_FLAGS);
    assign flag_clear = flag_wr ? wbits : {NUM_PINS{1'b0}};
    // One low cycle after any clear makes a fresh edge if flags remain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drop_r <= 1'b0;
        end else begin
            drop_r <= flag_wr;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ns_r <= `RST_SOURCE_SELECT;
        end else if (wr_en && wstrb_r[0] && reg_hit(waddr_r, `OFS_DETECT_SOURCE_SELECT)) begin
            mode_ns_r <= wdata_r[`MODE_STICKY_BIT];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_sec_r <= `RST_SOURCE_SELECT;
        end else if (wr_en && wsec_r && wstrb_r[0]
                     && reg_hit(waddr_r, `OFS_SECURE_DETECT_SOURCE_SEL)) begin
            mode_sec_r <= wdata_r[`MODE_STICKY_BIT];
        end
    end
    logic ns_merge;
    logic sec_merge;
    logic ns_sticky;
    logic sec_sticky;
    logic ns_hit_nxt;
    logic sec_hit_nxt;
    assign ns_merge    = |(detect & ~pin_ownership_map);
    assign sec_merge   = |(detect & pin_ownership_map);
    assign ns_sticky   = |(flags & ~pin_ownership_map) && !drop_r;
    assign sec_sticky  = |(flags & pin_ownership_map) && !drop_r;
    assign ns_hit_nxt  = mode_ns_r ? ns_sticky : ns_merge;
    assign sec_hit_nxt = mode_sec_r ? sec_sticky : sec_merge;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ns_hit_r  <= 1'b0;
            sec_hit_r <= 1'b0;
        end else begin
            ns_hit_r  <= ns_hit_nxt;
            sec_hit_r <= sec_hit_nxt;
        end
    end
    // Change event marks each rising port hit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ns_event_r  <= 1'b0;
            sec_event_r <= 1'b0;
        end else begin
            ns_event_r  <= ns_hit_nxt && !ns_hit_r;
            sec_event_r <= sec_hit_nxt && !sec_hit_r;
        end
    end
    assign nonsecure_port_hit   = ns_hit_r;
    assign secure_port_hit      = sec_hit_r;
    assign nonsecure_port_event = ns_event_r;
    assign secure_port_event    = sec_event_r;
    assign wake_request         = ns_hit_r | sec_hit_r;

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    logic [31:0]         rd_val;
    logic [NUM_PINS-1:0] rmask;
    logic                rsec;
    logic [4:0]          rd_idx;
    assign arready = !rvalid_r;
    assign rsec    = !arprot[1];
    assign rmask   = rsec ? {NUM_PINS{1'b1}} : ~pin_ownership_map;
    assign rd_idx  = cnf_index(araddr);
    always_comb begin
        rd_val = 32'h00000000;
        if (reg_hit(araddr, `OFS_PORT_OUTPUT_VALUE)
            || reg_hit(araddr, `OFS_PORT_OUTPUT_SET)
            || reg_hit(araddr, `OFS_PORT_OUTPUT_CLEAR)) begin
            rd_val[NUM_PINS-1:0] = out_r & rmask;
        end else if (reg_hit(araddr, `OFS_PORT_INPUT_VALUE)) begin
            rd_val[NUM_PINS-1:0] = level & rmask;
        end else if (reg_hit(araddr, `OFS_PORT_DIRECTION)
                     || reg_hit(araddr, `OFS_PORT_DIRECTION_SET)
                     || reg_hit(araddr, `OFS_PORT_DIRECTION_CLEAR)) begin
            rd_val[NUM_PINS-1:0] = dir_r & rmask;
        end else if (reg_hit(araddr, `OFS_STICKY_SENSE_FLAGS)) begin
            rd_val[NUM_PINS-1:0] = flags & rmask;
        end else if (reg_hit(araddr, `OFS_DETECT_SOURCE_SELECT)) begin
            rd_val[`MODE_STICKY_BIT] = mode_ns_r;
        end else if (reg_hit(araddr, `OFS_SECURE_DETECT_SOURCE_SEL)) begin
            rd_val[`MODE_STICKY_BIT] = mode_sec_r && rsec;
        end else if (cnf_hit(araddr) && (rsec || !pin_ownership_map[rd_idx])) begin
            rd_val[`CNF_DIR_BIT]                    = dir_r[rd_idx];
            rd_val[`CNF_DISCONNECT_BIT]             = disconnect_r[rd_idx];
            rd_val[`CNF_SENSE_MSB:`CNF_SENSE_LSB]   = sense_r[rd_idx];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign rvalid = rvalid_r;
    assign rdata  = rdata_r;
    assign rresp  = RESP_OKAY;

endmodule : gpio_sense_detect_security

// ---- src/gpio_sense_params.svh ----
// Purpose: Offsets, field positions and reset values of the sense/detect port
// Assumes: Byte addresses on a 12-bit register window
// Notes:   Definitions only
`ifndef GPIO_SENSE_PARAMS_SVH
`define GPIO_SENSE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_PORT_OUTPUT_VALUE        12'h004
`define OFS_PORT_OUTPUT_SET          12'h008
`define OFS_PORT_OUTPUT_CLEAR        12'h00C
`define OFS_PORT_INPUT_VALUE         12'h010
`define OFS_PORT_DIRECTION           12'h014
`define OFS_PORT_DIRECTION_SET       12'h018
`define OFS_PORT_DIRECTION_CLEAR     12'h01C
`define OFS_STICKY_SENSE_FLAGS       12'h020
`define OFS_DETECT_SOURCE_SELECT     12'h024
`define OFS_SECURE_DETECT_SOURCE_SEL 12'h028
`define OFS_PIN_CONFIGURATION_BASE   12'h200

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CNF_DIR_BIT                  0
`define CNF_DISCONNECT_BIT           1
`define CNF_SENSE_LSB                16
`define CNF_SENSE_MSB                17
`define MODE_STICKY_BIT              0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_PORT_OUTPUT              32'h00000000
`define RST_PORT_DIRECTION           32'h00000000
`define RST_INPUT_DISCONNECT         1'b1
`define RST_SOURCE_SELECT            1'b0

`endif

// ---- src/gpio_sense_pkg.sv ----
// Purpose: Types shared by the sense/detect port files
// Assumes: Constants live in gpio_sense_params.svh
// Notes:   Types only
package gpio_sense_pkg;

    // ------------------------------------------------------------------------
    // Sense selection of one pin
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SENSE_OFF  = 2'b00,
        SENSE_RSVD = 2'b01,
        SENSE_HIGH = 2'b10,
        SENSE_LOW  = 2'b11
    } sense_mode_t;

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00
    } axi_resp_t;

endpackage : gpio_sense_pkg

// ---- src/pin_sense_cell.sv ----
// Purpose: One pin: input synchroniser, level sense and sticky flag
// Assumes: pad_in is asynchronous to aclk
// Notes:   detect follows configuration changes without delay
`timescale 1ns/1ps
module pin_sense_cell (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // Pad and configuration
    input  wire logic                       pad_in,
    input  wire logic                       connected,
    input  wire gpio_sense_pkg::sense_mode_t sense_mode,
    // Flag control and results
    input  wire logic                       flag_clear,
    output logic                            level,
    output logic                            detect,
    output logic                            flag
);
    import gpio_sense_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic det_prev_r;
    logic flag_r;

    // ------------------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
        end
    end

    // Disconnected buffer hides the pad from input and sense
    assign level = sync2_r & connected;

    // ------------------------------------------------------------------------
    // Sense compare
    // ------------------------------------------------------------------------
    always_comb begin
        case (sense_mode)
            SENSE_HIGH: detect = connected & sync2_r;
            SENSE_LOW:  detect = connected & ~sync2_r;
            default:    detect = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_prev_r <= 1'b0;
        end else begin
            det_prev_r <= detect;
        end
    end

    // ------------------------------------------------------------------------
    // Sticky flag: a rising detect wins over a clear in the same cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 1'b0;
        end else if (detect && !det_prev_r) begin
            flag_r <= 1'b1;
        end else if (flag_clear && !detect) begin
            flag_r <= 1'b0;
        end
    end

    assign flag = flag_r;

endmodule : pin_sense_cell

// ---- verif/gpio_sense_chk.sv ----
// Purpose: Port-level properties of the sense/detect port
// Assumes: One aclk domain, sync active-low reset
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
module gpio_sense_chk (
    // Bus handshakes
    input wire logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready,
    input wire logic [31:0] rdata,
    input wire gpio_sense_pkg::axi_resp_t bresp, rresp,
    // Detect outputs
    input wire logic nonsecure_port_hit, secure_port_hit,
    input wire logic nonsecure_port_event, secure_port_event, wake_request
);
    import gpio_sense_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence answer_next;
        !bvalid ##1 bvalid;
    endsequence
    chk_write_answer: assert property (both_taken |=> answer_next)
        else $error("write answer not on time");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer not on time");
    chk_bresp_okay: assert property (bvalid |-> bresp == RESP_OKAY)
        else $error("write answer not okay");
    chk_rresp_okay: assert property (rvalid |-> rresp == RESP_OKAY)
        else $error("read answer not okay");
    chk_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data moved before taken");
    chk_wake_or: assert property (wake_request == (nonsecure_port_hit || secure_port_hit))
        else $error("wake request not hit or");
    chk_ns_event: assert property (nonsecure_port_event == $rose(nonsecure_port_hit))
        else $error("non-secure event wrong");
    chk_sec_event: assert property (secure_port_event == $rose(secure_port_hit))
        else $error("secure event wrong");
endmodule : gpio_sense_chk

bind gpio_sense_detect_security gpio_sense_chk gpio_sense_chk_inst (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata,
    .bresp, .rresp, .nonsecure_port_hit, .secure_port_hit, .nonsecure_port_event,
    .secure_port_event, .wake_request);

// ---- verif/gpio_sense_detect_security_tb_top.sv ----
// Purpose: Register-level test of the sense/detect port
// Assumes: Pin 0 non-secure, pin 16 secure
// Notes:   Non-secure flag is the middle awprot/arprot bit
`timescale 1ns/1ps
`include "gpio_sense_params.svh"
module gpio_sense_detect_security_tb_top;
    import gpio_sense_pkg::*;
    localparam logic [11:0] C0 = `OFS_PIN_CONFIGURATION_BASE;
    localparam logic [11:0] C16 = `OFS_PIN_CONFIGURATION_BASE + 12'h040;
    localparam logic [11:0] FL = `OFS_STICKY_SENSE_FLAGS;
    localparam logic [11:0] SS = `OFS_SECURE_DETECT_SOURCE_SEL;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic nonsecure_port_hit, secure_port_hit, nonsecure_port_event, secure_port_event;
    logic wake_request;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0, want = 32'h0, rdata, pad_in, pin_ownership_map, oe;
    axi_resp_t bresp, rresp;
    int mismatches = 0, total_checks = 0;
    gpio_sense_detect_security gpio_sense_detect_security_inst (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp,
        .pad_in, .pad_out(), .pad_oe(oe), .pin_ownership_map, .nonsecure_port_hit,
        .secure_port_hit, .nonsecure_port_event, .secure_port_event, .wake_request);
    pad_model pad_model_inst (.aclk, .want, .pad_in, .pin_ownership_map);
    initial forever #25 aclk = ~aclk;
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic hang;
        mismatches++;
        final_report;
    endtask : hang
    // Bus masters sample ready mid-cycle; inputs only move right after a rising edge
    task automatic wr(input logic [11:0] a, input logic ns, input logic [31:0] d);
        logic ta, tw, done;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awaddr <= a;
        wdata <= d;
        awprot <= {1'b0, ns, 1'b0};
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            done = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!done) hang;
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic ns, input logic [31:0] e);
        logic ta, done;
        logic [31:0] v;
        @(posedge aclk);
        arvalid <= 1'b1;
        rready <= 1'b1;
        araddr <= a;
        arprot <= {1'b0, ns, 1'b0};
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge aclk);
            ta = arvalid & arready;
            done = rvalid;
            v = rdata;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!done) hang;
        check($sformatf("read %h", a), v, e);
    endtask : rc
    // Pad register plus two sync stages plus hit register
    task automatic settle;
        repeat (5) @(negedge aclk);
    endtask : settle
    task automatic pin(input int i, input logic v);
        @(posedge aclk);
        want[i] <= v;
        settle;
    endtask : pin
    task automatic hits(input logic [1:0] e);
        check("hits", {30'h0, nonsecure_port_hit, secure_port_hit}, {30'h0, e});
    endtask : hits
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rc(C0, 1'b1, 32'h2);
        rc(FL, 1'b1, 32'h0);
        pin(0, 1'b1);
        rc(`OFS_PORT_INPUT_VALUE, 1'b1, 32'h0);
        wr(C0, 1'b1, 32'h20000);
        settle;
        hits(2'h2);
        rc(`OFS_PORT_INPUT_VALUE, 1'b1, 32'h1);
        rc(FL, 1'b1, 32'h1);
        wr(FL, 1'b1, 32'h1);
        rc(FL, 1'b1, 32'h1);
        pin(0, 1'b0);
        hits(2'h0);
        rc(FL, 1'b1, 32'h1);
        wr(FL, 1'b1, 32'h1);
        rc(FL, 1'b1, 32'h0);
        wr(`OFS_DETECT_SOURCE_SELECT, 1'b1, 32'h1);
        pin(0, 1'b1);
        wr(FL, 1'b1, 32'h1);
        @(negedge aclk);
        hits(2'h0);
        pin(0, 1'b0);
        hits(2'h2);
        wr(FL, 1'b1, 32'h1);
        settle;
        hits(2'h0);
        rc(C16, 1'b1, 32'h0);
        wr(C16, 1'b1, 32'h30000);
        rc(C16, 1'b0, 32'h2);
        wr(C16, 1'b0, 32'h30000);
        settle;
        hits(2'h1);
        rc(FL, 1'b1, 32'h0);
        pin(16, 1'b1);
        wr(FL, 1'b1, 32'h10000);
        rc(FL, 1'b0, 32'h10000);
        wr(FL, 1'b0, 32'h10000);
        rc(FL, 1'b0, 32'h0);
        wr(SS, 1'b1, 32'h1);
        rc(SS, 1'b0, 32'h0);
        wr(SS, 1'b0, 32'h1);
        rc(SS, 1'b1, 32'h0);
        rc(SS, 1'b0, 32'h1);
        rc(12'h100, 1'b1, 32'h0);
        wr(`OFS_PORT_DIRECTION_SET, 1'b1, 32'hFFFFFFFF);
        rc(`OFS_PORT_DIRECTION, 1'b0, 32'h0000FFFF);
        check("pad_oe", oe, 32'h0000FFFF);
        final_report;
    end
endmodule : gpio_sense_detect_security_tb_top

// ---- verif/pad_model.sv ----
// Purpose: Pads and protection unit facing the port
// Assumes: Pads always driven, levels set by the bench
// Notes:   Upper half of the pins is secure
`timescale 1ns/1ps
module pad_model #(parameter logic [31:0] SEC_MASK = 32'hFFFF0000) (
    input  wire logic        aclk,
    input  wire logic [31:0] want,
    output logic      [31:0] pad_in,
    output logic      [31:0] pin_ownership_map
);
    // Bench parks a pin before sensing and holds each level well over three cycles
    always_ff @(posedge aclk) pad_in <= want;
    assign pin_ownership_map = SEC_MASK;
endmodule : pad_model
